// ==== core/acrb_defines.vh ====
/*
  Address map, reset values and timing counts of the converter
  configuration register bank.
  Assumes it is included by the bank module only.
*/
`ifndef ACRB_DEFINES_VH
`define ACRB_DEFINES_VH

`define ACRB_AW          9
`define ACRB_PORT_CFG    9'h000
`define ACRB_CHIP_ID     9'h001
`define ACRB_CHIP_GRADE  9'h002
`define ACRB_CHAN_SEL    9'h005
`define ACRB_COMMIT      9'h0FF
`define ACRB_FUNC_LO     9'h008
`define ACRB_FUNC_HI     9'h018
`define ACRB_REF_SEL     9'h018
`define ACRB_DIG_LO      9'h100
`define ACRB_DIG_SH_LO   9'h11E
`define ACRB_DIG_HI      9'h123

`define ACRB_PORT_CFG_RST 8'h18
`define ACRB_CHAN_SEL_RST 2'h3
`define ACRB_REF_SEL_RST  8'hC0
`define ACRB_ZERO_BYTE    8'h00
`define ACRB_COMMIT_BIT   0

`define ACRB_STRAP_STABILIZER 0
`define ACRB_STRAP_FORMAT     1
`define ACRB_STRAP_OUTPUT_DIS 2
`define ACRB_STRAP_POWERDOWN  3

`define ACRB_STRAP_WAIT  2'h3

`endif

// ==== core/acrb_config_bank.v ====
/*
  Configuration register bank of a dual-channel converter: strap
  fallback, address decode, shadow/active register pairs committed by
  a transfer command, and per-channel copies of local registers.
  Assumes a serial deserializer on clk_sys presents byte accesses on
  the reg* port, and that the four strap pins and the serial select
  pin arrive asynchronously.
*/
// Functional notes
// [RQ1] serial select held high disables the configuration port.
// [RQ2] with the port disabled, four dual pins are straps sampled at power-up.
// [RQ3] straps give stabilizer enable, twos complement format, output disable.
// [RQ4] powerdown strap high means power-down or standby, low is normal.
// [RQ5] decode chip config, channel index/transfer, function, digital regions.
// [RQ6] unsupported addresses and bits do nothing and read as zero.
// [RQ7] host writes zeros into unused bits of partly open registers.
// [RQ8] host never writes a fully open address.
// [RQ9] reset loads every register with its default value.
// [RQ10] reference select resets to C0 hex, the 2.0 V reference.
// [RQ11] function and upper digital registers are holding/active pairs.
// [RQ12] writing a holding register leaves the active setting alone.
// [RQ13] writing 01 to the transfer register commits all pairs at once.
// [RQ14] the transfer bit clears itself once the commit is done.
// [RQ15] local registers have an independent copy per channel.
// [RQ16] channel-select bits steer local register accesses.
// [RQ17] both select bits set: a local write updates both copies.
// [RQ18] host sets exactly one select bit before reading a local register.
// [RQ19] both select bits set on a local read returns channel one.
// [RQ20] global registers have one copy, unaffected by channel select.
// [RQ21] every register in the map is readable and writable by the host; here chip ID and chip grade are read-only parameters.
// [RQ22] select bit 0 is channel one, bit 1 channel two, both set at reset.
// [RQ23] transfer register reads zero after clearing; writing zero is inert.
`timescale 1ns/1ns
`include "acrb_defines.vh"

module acrb_config_bank #(
  parameter                 NS         = 23,
  parameter                 ND         = 30,
  parameter [NS-1:0]        LOCAL_MASK = 23'h7EFFFF,
  // arbitrary identification values
  parameter [7:0]           CHIP_ID    = 8'h5A,
  parameter [7:0]           CHIP_GRADE = 8'h00
) (
  input  wire                   clk_sys,
  input  wire                   rstn,
  input  wire                   serialSelectN,
  input  wire                   serialIoOrStabilizerStrap,
  input  wire                   serialClockOrFormatStrap,
  input  wire                   monitorOutOrOutputDisableStrap,
  input  wire                   monitorClockOrPowerdownStrap,
  input  wire                   regWrite,
  input  wire                   regRead,
  input  wire [`ACRB_AW-1:0]    regAddr,
  input  wire [7:0]             regWrData,
  output reg  [7:0]             regRdData,
  output reg                    regRdValid,
  output reg                    portEnabled,
  output reg                    strapsValid,
  output reg                    dutyCycleStabilizer,
  output reg                    twosComplement,
  output reg                    outputsHiZ,
  output reg                    powerDown,
  output reg  [7:0]             portConfig,
  output reg  [1:0]             channelSelect,
  output reg                    commitPulse,
  output wire [NS*8-1:0]        activeChanA,
  output wire [NS*8-1:0]        activeChanB,
  output wire [ND*8-1:0]        directRegs
);

  reg  [3:0] strapMeta;
  reg  [3:0] strapSync;
  reg        selMeta;
  reg        selSync;
  reg  [1:0] strapWait;

  wire [NS*8-1:0] holdChanA;
  wire [NS*8-1:0] holdChanB;

  // pins are asynchronous to the sample clock
  always @(posedge clk_sys) begin
    if (!rstn) begin
      strapMeta <= 4'h0;
      strapSync <= 4'h0;
      selMeta   <= 1'b1;
      selSync   <= 1'b1;
    end else begin
      strapMeta <= {monitorClockOrPowerdownStrap,
                    monitorOutOrOutputDisableStrap,
                    serialClockOrFormatStrap,
                    serialIoOrStabilizerStrap};
      strapSync <= strapMeta;
      selMeta   <= serialSelectN;
      selSync   <= selMeta;
    end
  end

  // [RQ2] strap capture once
  // the wait lets the synchroniser fill before the pins are trusted
  always @(posedge clk_sys) begin
    if (!rstn) begin
      strapWait           <= 2'h0;
      strapsValid         <= 1'b0;
      dutyCycleStabilizer <= 1'b1;
      twosComplement      <= 1'b0;
      outputsHiZ          <= 1'b0;
      powerDown           <= 1'b0;
    end else if (!strapsValid) begin
      if (strapWait == `ACRB_STRAP_WAIT) begin
        strapsValid         <= 1'b1;
        // [RQ3] strap decode
        dutyCycleStabilizer <= strapSync[`ACRB_STRAP_STABILIZER];
        twosComplement      <= strapSync[`ACRB_STRAP_FORMAT];
        outputsHiZ          <= strapSync[`ACRB_STRAP_OUTPUT_DIS];
        // [RQ4] powerdown strap
        powerDown           <= strapSync[`ACRB_STRAP_POWERDOWN];
      end else begin
        strapWait <= strapWait + 2'h1;
      end
    end
  end

  // [RQ1] port enable on select
  // a select that stays high leaves the straps in charge for good;
  // once seen low the port stays on, since select idles high between frames
  always @(posedge clk_sys) begin
    if (!rstn)
      portEnabled <= 1'b0;
    else if (strapsValid && !selSync)
      portEnabled <= 1'b1;
  end

  wire wrEn = portEnabled & regWrite;
  wire rdEn = portEnabled & regRead;

  // [RQ5] region decode
  wire isFunc  = (regAddr >= `ACRB_FUNC_LO) && (regAddr <= `ACRB_FUNC_HI);
  wire isDigSh = (regAddr >= `ACRB_DIG_SH_LO) && (regAddr <= `ACRB_DIG_HI);
  wire isDir   = (regAddr >= `ACRB_DIG_LO) && (regAddr < `ACRB_DIG_SH_LO);
  wire isShad  = isFunc | isDigSh;
  wire [`ACRB_AW-1:0] funcOff = regAddr - `ACRB_FUNC_LO;
  wire [`ACRB_AW-1:0] digOff  = regAddr - `ACRB_DIG_SH_LO
                                + (`ACRB_FUNC_HI - `ACRB_FUNC_LO + 9'h001);
  wire [`ACRB_AW-1:0] shIdx   = isFunc ? funcOff : digOff;
  wire [`ACRB_AW-1:0] dIdx    = regAddr - `ACRB_DIG_LO;
  wire [`ACRB_AW-1:0] refIdx  = `ACRB_REF_SEL - `ACRB_FUNC_LO;

  // global chip and channel index registers
  always @(posedge clk_sys) begin
    if (!rstn) begin
      // [RQ9] global defaults
      portConfig    <= `ACRB_PORT_CFG_RST;
      // [RQ22] both channels selected
      channelSelect <= `ACRB_CHAN_SEL_RST;
    end else if (wrEn) begin
      // [RQ21] host writes
      if (regAddr == `ACRB_PORT_CFG)
        portConfig <= regWrData;
      if (regAddr == `ACRB_CHAN_SEL)
        channelSelect <= regWrData[1:0];
    end
  end

  // [RQ14] self-clearing transfer
  // the bit lives one cycle: set by the write, gone after the copy
  always @(posedge clk_sys) begin
    if (!rstn)
      commitPulse <= 1'b0;
    // [RQ23] zero write inert
    else if (wrEn && regAddr == `ACRB_COMMIT)
      commitPulse <= regWrData[`ACRB_COMMIT_BIT];
    else
      commitPulse <= 1'b0;
  end

  genvar i;
  generate
    for (i = 0; i < NS; i = i + 1) begin : gShadow
      reg  [7:0] holdA;
      reg  [7:0] holdB;
      reg  [7:0] actA;
      reg  [7:0] actB;
      wire [7:0] rstVal = (refIdx == i) ? `ACRB_REF_SEL_RST
                                        : `ACRB_ZERO_BYTE;
      wire       hit    = wrEn & isShad & (shIdx == i);
      // [RQ16] channel steering
      // [RQ20] global entries ignore select
      wire       wrA    = hit & (channelSelect[0] | ~LOCAL_MASK[i]);
      // [RQ17] both-channel write
      wire       wrB    = hit & channelSelect[1] & LOCAL_MASK[i];
      always @(posedge clk_sys) begin
        if (!rstn) begin
          // [RQ10] reference default
          holdA <= rstVal;
          holdB <= rstVal;
          actA  <= rstVal;
          actB  <= rstVal;
        end else begin
          // [RQ12] holding only
          if (wrA)
            holdA <= regWrData;
          if (wrB)
            holdB <= regWrData;
          // [RQ13] simultaneous commit
          if (commitPulse) begin
            actA <= holdA;
            actB <= LOCAL_MASK[i] ? holdB : holdA;
          end
        end
      end
      // [RQ11] holding and active pair
      // [RQ15] per-channel copies
      assign holdChanA[i*8 +: 8]   = holdA;
      assign holdChanB[i*8 +: 8]   = holdB;
      assign activeChanA[i*8 +: 8] = actA;
      assign activeChanB[i*8 +: 8] = LOCAL_MASK[i] ? actB : actA;
    end

    for (i = 0; i < ND; i = i + 1) begin : gDirect
      reg [7:0] val;
      always @(posedge clk_sys) begin
        if (!rstn)
          val <= `ACRB_ZERO_BYTE;
        else if (wrEn && isDir && dIdx == i)
          val <= regWrData;
      end
      assign directRegs[i*8 +: 8] = val;
    end
  endgenerate

  reg [7:0] next_rdData;

  always @* begin
    next_rdData = `ACRB_ZERO_BYTE;
    if (isShad) begin
      // [RQ19] channel one wins
      if (channelSelect[0] || !channelSelect[1] ||
          !LOCAL_MASK[shIdx[4:0]])
        next_rdData = holdChanA[shIdx*8 +: 8];
      else
        next_rdData = holdChanB[shIdx*8 +: 8];
    end else if (isDir) begin
      next_rdData = directRegs[dIdx*8 +: 8];
    end else begin
      // [RQ6] unmapped reads zero
      case (regAddr)
        `ACRB_PORT_CFG:   next_rdData = portConfig;
        `ACRB_CHIP_ID:    next_rdData = CHIP_ID;
        `ACRB_CHIP_GRADE: next_rdData = CHIP_GRADE;
        `ACRB_CHAN_SEL:   next_rdData = {6'h00, channelSelect};
        `ACRB_COMMIT:     next_rdData = {7'h00, commitPulse};
        default:          next_rdData = `ACRB_ZERO_BYTE;
      endcase
    end
  end

  always @(posedge clk_sys) begin
    if (!rstn) begin
      regRdData  <= `ACRB_ZERO_BYTE;
      regRdValid <= 1'b0;
    end else begin
      regRdValid <= rdEn;
      if (rdEn)
        regRdData <= next_rdData;
    end
  end

endmodule

// ==== dv/acrb_config_bank_asserts.sv ====
/* Port checker for the config bank.
   Assumes binding into acrb_config_bank. */
`timescale 1ns/1ns
module acrb_config_bank_asserts #(
  parameter NS = 23
) (
  input wire logic          clk_sys,
  input wire logic          rstn,
  input wire logic          regWrite,
  input wire logic          regRead,
  input wire logic [8:0]    regAddr,
  input wire logic [7:0]    regWrData,
  input wire logic [7:0]    regRdData,
  input wire logic          regRdValid,
  input wire logic          portEnabled,
  input wire logic          strapsValid,
  input wire logic          dutyCycleStabilizer,
  input wire logic          twosComplement,
  input wire logic          outputsHiZ,
  input wire logic          powerDown,
  input wire logic [7:0]    portConfig,
  input wire logic [1:0]    channelSelect,
  input wire logic          commitPulse,
  input wire logic [NS*8-1:0] activeChanA,
  input wire logic [NS*8-1:0] activeChanB
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  wire       wrFf      = portEnabled && regWrite && regAddr == 9'h0FF;
  wire       commitReq = wrFf && regWrData[0];
  wire [1:0] selWrBits = regWrData[1:0];
  wire [3:0] strapOut  = {dutyCycleStabilizer, twosComplement,
                          outputsHiZ, powerDown};
  rd_answer_a: assert property (
    portEnabled && regRead |=> regRdValid)
    else $error("read not answered");
  rd_refused_a: assert property (
    !(portEnabled && regRead) |=> !regRdValid)
    else $error("unrequested read valid");
  commit_start_a: assert property (
    commitReq |=> commitPulse)
    else $error("commit pulse missing");
  commit_cause_a: assert property (
    commitPulse |-> $past(commitReq))
    else $error("commit without cause");
  commit_clear_a: assert property (
    commitPulse |=> !commitPulse)
    else $error("transfer bit stuck");
  active_hold_a: assert property (
    !commitPulse |=> $stable(activeChanA) && $stable(activeChanB))
    else $error("active changed without commit");
  reset_value_a: assert property (
    $rose(rstn) |-> channelSelect == 2'h3 && portConfig == 8'h18
    && activeChanA[135:128] == 8'hC0)
    else $error("bad reset value");
  sel_write_a: assert property (
    portEnabled && regWrite && regAddr == 9'h005
    |=> channelSelect == $past(selWrBits))
    else $error("select not written");
  straps_fixed_a: assert property (
    strapsValid && $past(strapsValid) |-> $stable(strapOut))
    else $error("strap outputs moved");
  port_gate_a: assert property (
    !strapsValid |-> !portEnabled)
    else $error("port enabled before straps");
  unmapped_rd_a: assert property (
    portEnabled && regRead && regAddr == 9'h003 |=> regRdData == 8'h00)
    else $error("unmapped read not zero");
endmodule

bind acrb_config_bank acrb_config_bank_asserts #(.NS(NS)) u_chk (.*);

// ==== dv/acrb_host_model.sv ====
/* Host side of the register byte port.
   Assumes the bank takes a request at the rising clock edge. */
`timescale 1ns/1ns
module acrb_host_model (
  input  wire       clk_sys,
  input  wire [7:0] regRdData,
  input  wire       regRdValid,
  output reg        regWrite,
  output reg        regRead,
  output reg  [8:0] regAddr,
  output reg  [7:0] regWrData
);
  initial begin
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 9'h1FF;
    regWrData = 8'hFF;
  end
  // mapped bytes only
  // one idle edge first, so back-to-back calls never reassign a line
  task wr(input [8:0] a, input [7:0] d);
    @(posedge clk_sys);
    #1;
    regAddr = a;
    regWrData = d;
    regWrite = 1'b1;
    @(posedge clk_sys);
    #1 regWrite = 1'b0;
    // idle lines show the inverse, not a stale copy
    regAddr = ~a;
    regWrData = ~d;
  endtask
  task rd(input [8:0] a, output [7:0] q, output ok);
    @(posedge clk_sys);
    #1;
    regAddr = a;
    regRead = 1'b1;
    @(posedge clk_sys);
    #1 regRead = 1'b0;
    regAddr = ~a;
    ok = regRdValid;
    q = regRdData;
  endtask
endmodule

// ==== dv/acrb_config_bank_tb.sv ====
/* Self-checking bench for the config bank.
   Assumes default bank parameters and the host model. */
`timescale 1ns/1ns
module acrb_config_bank_tb;
  reg          clk_sys, rstn, selN;
  reg  [3:0]   strap;
  wire         wr, rd, vld, pe, sv, duty_cycle_stabilizer, tc, hz, pd, cp;
  wire [8:0]   adr;
  wire [7:0]   wd, q, pc;
  wire [1:0]   cs;
  wire [183:0] actA, actB;
  wire [239:0] dir;
  integer      errors, cmp_count, k;
  integer      cyc = 0;
  reg  [31:0]  lf;
  reg  [1:0]   mcs;
  reg  [7:0]   rdByte;
  reg          rdOk;
  reg  [7:0]   hA[0:511], hB[0:511], aA[0:22], aB[0:22];

  acrb_config_bank dut (.clk_sys(clk_sys), .rstn(rstn),
    .serialSelectN(selN), .serialIoOrStabilizerStrap(strap[0]),
    .serialClockOrFormatStrap(strap[1]),
    .monitorOutOrOutputDisableStrap(strap[2]),
    .monitorClockOrPowerdownStrap(strap[3]), .regWrite(wr),
    .regRead(rd), .regAddr(adr), .regWrData(wd), .regRdData(q),
    .regRdValid(vld), .portEnabled(pe), .strapsValid(sv),
    .dutyCycleStabilizer(duty_cycle_stabilizer), .twosComplement(tc), .outputsHiZ(hz),
    .powerDown(pd), .portConfig(pc), .channelSelect(cs),
    .commitPulse(cp), .activeChanA(actA), .activeChanB(actB),
    .directRegs(dir));
  acrb_host_model host (.clk_sys(clk_sys), .regRdData(q),
    .regRdValid(vld), .regWrite(wr), .regRead(rd), .regAddr(adr),
    .regWrData(wd));

  function [31:0] nx(input [31:0] v);
    nx = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function loc(input [8:0] a);
    loc = (a >= 9'h008 && a <= 9'h017) || (a >= 9'h11E && a <= 9'h123);
  endfunction
  task cmp(input [7:0] got, input [7:0] exp);
    cmp_count = cmp_count + 1;
    if (got !== exp) begin
      errors = errors + 1;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task w(input [8:0] a, input [7:0] d);
    if (!loc(a) || mcs[0]) hA[a] = d;
    if (!loc(a) || mcs[1]) hB[a] = d;
    if (a == 9'h005) mcs = d[1:0];
    if (a == 9'h0FF && d[0]) for (k = 0; k < 23; k = k + 1) begin
      aA[k] = hA[k < 17 ? k + 8 : k + 9'h10D];
      aB[k] = hB[k < 17 ? k + 8 : k + 9'h10D];
    end
    hA[9'h0FF] = 8'h00;
    host.wr(a, d);
  endtask
  task r(input [8:0] a);
    reg [7:0] got;
    reg       ok;
    host.rd(a, got, ok);
    cmp({7'h0, ok}, 8'h01);
    cmp(got, (loc(a) && mcs == 2'h2) ? hB[a] : hA[a]);
  endtask
  task chk;
    for (k = 0; k < 23; k = k + 1) begin
      cmp(actA[k*8+:8], aA[k]);
      cmp(actB[k*8+:8], aB[k]);
    end
    for (k = 0; k < 30; k = k + 1) cmp(dir[k*8+:8], hA[9'h100 + k]);
  endtask
  task cm;
    w(9'h0FF, 8'h01);
    cmp({7'h0, cp}, 8'h01);
    @(posedge clk_sys);
    #1 cmp({7'h0, cp}, 8'h00);
    chk;
  endtask
  task end_of_test;
    $display("errors=%0d comparisons=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // under a hundred cycles expected
  always @(posedge clk_sys) begin
    cyc = cyc + 1;
    if (cyc == 2000) begin
      errors = errors + 1;
      end_of_test;
    end
  end

  initial begin
    errors = 0;
    cmp_count = 0;
    lf = 32'hABED;
    rstn = 1'b0;
    selN = 1'b0;
    strap = lf[3:0];
    mcs = 2'h3;
    for (k = 0; k < 512; k = k + 1) hA[k] = 8'h00;
    for (k = 0; k < 512; k = k + 1) hB[k] = 8'h00;
    for (k = 0; k < 23; k = k + 1) aA[k] = 8'h00;
    for (k = 0; k < 23; k = k + 1) aB[k] = 8'h00;
    hA[0] = 8'h18;
    hA[5] = 8'h03;
    hA[24] = 8'hC0;
    hB[24] = 8'hC0;
    aA[16] = 8'hC0;
    aB[16] = 8'hC0;
    repeat (6) @(posedge clk_sys);
    #1 rstn = 1'b1;
    repeat (8) @(posedge clk_sys);
    #1 cmp({7'h0, pe}, 8'h01);
    cmp({7'h0, sv}, 8'h01);
    cmp(pc, 8'h18);
    cmp({6'h0, cs}, 8'h03);
    chk;
    cmp({4'h0, pd, hz, tc, duty_cycle_stabilizer}, {4'h0, strap});
    strap = ~strap;
    repeat (3) @(posedge clk_sys);
    #1 cmp({4'h0, pd, hz, tc, duty_cycle_stabilizer}, {4'h0, ~strap});
    lf = nx(lf);
    w(9'h010, lf[7:0]);
    chk;
    r(9'h010);
    cm;
    w(9'h005, 8'h01);
    w(9'h009, lf[15:8]);
    w(9'h005, 8'h02);
    w(9'h009, lf[23:16]);
    w(9'h11E, lf[31:24]);
    w(9'h018, (lf[7:0] ^ 8'h5A) & 8'hC0);
    r(9'h009);
    w(9'h005, 8'h03);
    r(9'h009);
    w(9'h0FF, 8'h00);
    chk;
    cm;
    lf = nx(lf);
    w(9'h100, lf[7:0]);
    w(9'h123, lf[15:8]);
    r(9'h003);
    r(9'h000);
    r(9'h0FF);
    chk;
    // select tied high keeps the port off after a new reset
    lf = nx(lf);
    rstn = 1'b0;
    selN = 1'b1;
    strap = lf[3:0];
    repeat (6) @(posedge clk_sys);
    #1 rstn = 1'b1;
    repeat (8) @(posedge clk_sys);
    #1 cmp({4'h0, pd, hz, tc, duty_cycle_stabilizer}, {4'h0, strap});
    cmp({7'h0, pe}, 8'h00);
    for (k = 0; k < 23; k = k + 1) begin
      aA[k] = (k == 16) ? 8'hC0 : 8'h00;
      aB[k] = aA[k];
    end
    for (k = 256; k < 286; k = k + 1) hA[k] = 8'h00;
    chk;
    host.wr(9'h005, 8'h01);
    host.rd(9'h005, rdByte, rdOk);
    cmp({7'h0, rdOk}, 8'h00);
    cmp(rdByte, 8'h00);
    cmp({6'h0, cs}, 8'h03);
    end_of_test;
  end
endmodule
